// [pmu_ctrl_regs.svh]
`ifndef PMU_CTRL_REGS_SVH
`define PMU_CTRL_REGS_SVH

// Byte offsets of the documented registers (each at its own byte address)
`define OFF_SYS_MON        8'h00
`define OFF_SYS_MASTER     8'h01
`define OFF_BUCK1_PRI      8'h20
`define OFF_BUCK1_SEC      8'h21
`define OFF_BUCK1_CTL      8'h22
// Interrupt status and mask, chosen offsets
`define OFF_IRQ_STATUS     8'h80
`define OFF_IRQ_MASK       8'h81

// Field positions
`define SYS_TRST_BIT       7
`define SYS_RESP_BIT       6
`define SYS_UNMASK_BIT     5
`define SYS_LOW_BIT        4
`define MST_OFF_BIT        5
`define CTL_ON_BIT         7
`define CTL_PHASE_BIT      6
`define CTL_MODE_BIT       5
`define CTL_FLT_BIT        1
`define CTL_OK_BIT         0

// Writable masks
`define SYS_MON_WMASK      8'hEF
`define SYS_MST_WMASK      8'hFF
`define VSET_WMASK         8'h3F
`define CTL_WMASK          8'hFE
`define IRQ_WMASK          8'h03

// Reset values
`define SYS_MON_RST        8'h00
`define SYS_MST_RST        8'h00
`define BUCK1_PRI_RST      8'h24
`define BUCK1_SEC_RST      8'h24
`define BUCK1_CTL_RST      8'hA4
`define IRQ_MASK_RST       8'h00

// Interrupt status bits
`define IRQ_SYSV_BIT       0
`define IRQ_FAULT_BIT      1

// Reset time-out figures in ms and in 40 MHz cycles
`define CLK_HZ             40000000
`define RST_SHORT_MS       64
`define RST_LONG_MS        260
`define RST_SHORT_CYC      (`RST_SHORT_MS * (`CLK_HZ / 1000))
`define RST_LONG_CYC       (`RST_LONG_MS * (`CLK_HZ / 1000))

`endif

// [pmu_ctrl_pkg.sv]
package pmu_ctrl_pkg;
    typedef enum logic [2:0] {
        ST_RUN   = 3'b001,
        ST_HOLD  = 3'b010,
        ST_SHDN  = 3'b100
    } pwr_state_t;
endpackage

// [sysv_link_if.sv]
`timescale 1ns/1ps
interface sysv_link_if;
    logic       sysv_low;
    logic       low_event;
    modport ctrl (input sysv_low, input low_event);
    modport mon  (output sysv_low, output low_event);
endinterface

// [sysv_monitor.sv]
`timescale 1ns/1ps
module sysv_monitor (
    input  wire logic core_clk_i,
    input  wire logic reset_n_i,
    input  wire logic below_i,
    sysv_link_if.mon  link
);
    logic below_q;
    logic low_q;
    logic event_q;

    ////////////////////////////////////////////////////////////////
    // Register the comparator level and flag its rising edge
    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            below_q <= 1'b0;
            low_q   <= 1'b0;
            event_q <= 1'b0;
        end else begin
            below_q <= below_i;
            low_q   <= below_q;
            event_q <= below_q & ~low_q;
        end
    end

    assign link.sysv_low  = low_q;
    assign link.low_event = event_q;
endmodule

// [pmu_ctrl_regs.sv]
// Functional notes
// R1: Reset time-out bit selects 64 ms when 1 and 260 ms when 0.
// R2: Response bit picks interrupt when 1 or automatic shutdown when 0 on low supply.
// R3: Supply-low interrupt is masked after reset and passes only once its unmask bit is 1.
// R4: Read-only supply-low status reads 1 while supply is below threshold.
// R5: Four-bit threshold code sits in bits 3:0 of the monitor register.
// R6: Master-off bit turns all regulators off and self-clears on push button.
// R7: Four scratch bits store only and clear on undervoltage.
// R8: Primary voltage code drives the output while the select pin is low.
// R9: Secondary voltage code drives the output while the select pin is high.
// R10: Enable bit turns the first regulator on when 1 and off when 0.
// R11: Phase bit selects 180 degree or in-phase operation.
// R12: Mode bit forces PWM when 1, allows power saving when 0.
// R13: Three-bit field selects turn-on delay.
// R14: Fault mask bit lets fault interrupts through when 1.
// R15: Read-only power-OK bit reflects the regulator output.
// R16: Every bit returns to default on undervoltage.
// R17: Registers are eight bits wide at byte addresses; read-only bits ignore writes.
//
// Design decision made here: the Wishbone interface to the registers.
`timescale 1ns/1ps
`include "pmu_ctrl_regs.svh"
module pmu_ctrl_regs (
    input  wire logic        core_clk_i,
    input  wire logic        reset_n_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic        uvlo_i,
    input  wire logic        sysv_below_i,
    input  wire logic        push_button_input_n_i,
    input  wire logic        voltage_select_pin_i,
    input  wire logic        buck1_pgood_i,
    input  wire logic        buck1_fault_i,
    input  wire logic        reset_trigger_i,
    output logic      [3:0]  sysv_threshold_code_o,
    output logic      [5:0]  buck1_voltage_code_o,
    output logic             buck1_enable_o,
    output logic             buck1_phase_o,
    output logic             buck1_force_pwm_o,
    output logic      [2:0]  buck1_delay_o,
    output logic             all_regs_off_o,
    output logic             reset_out_n_o,
    output logic             irq_o
);
    logic [7:0]               mon_q;
    logic [7:0]               mst_q;
    logic [7:0]               pri_q;
    logic [7:0]               sec_q;
    logic [7:0]               ctl_q;
    logic [1:0]               irq_stat_q;
    logic [1:0]               irq_mask_q;
    logic                     pgood_q;
    logic                     fault_q;
    logic [23:0]              rst_cnt_q;
    pmu_ctrl_pkg::pwr_state_t state_q;
    logic                     wr_en;
    logic                     rd_en;
    logic [7:0]               wdat;
    logic                     sysv_low;
    logic [1:0]               irq_set;
    logic                     shut_req;

    sysv_link_if link ();

    sysv_monitor u_mon (
        .core_clk_i (core_clk_i),
        .reset_n_i  (reset_n_i),
        .below_i    (sysv_below_i),
        .link       (link.mon)
    );

    assign sysv_low = link.sysv_low;

    ////////////////////////////////////////////////////////////////
    // Bus decode; only byte lane 0 carries data
    assign wr_en = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o & wb_sel_i[0];
    assign rd_en = wb_cyc_i & wb_stb_i & ~wb_we_i & ~wb_ack_o;
    assign wdat  = wb_dat_i[7:0];

    // Ack one cycle after the strobe, dropped the next cycle
    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Monitor register: supply-low status bit is never stored
    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            mon_q <= `SYS_MON_RST;
        end else if (uvlo_i) begin
            mon_q <= `SYS_MON_RST; // see R16
        end else if (wr_en && wb_adr_i == `OFF_SYS_MON) begin
            mon_q <= wdat & `SYS_MON_WMASK; // see R5 see R17
        end
    end

    // Master register; push button wins over a write of master-off
    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            mst_q <= `SYS_MST_RST;
        end else if (uvlo_i) begin
            mst_q <= `SYS_MST_RST; // see R7 see R16
        end else begin
            if (wr_en && wb_adr_i == `OFF_SYS_MASTER) begin
                mst_q <= wdat & `SYS_MST_WMASK;
            end
            if (!push_button_input_n_i) begin
                mst_q[`MST_OFF_BIT] <= 1'b0; // see R6
            end
        end
    end

    // First regulator voltage and control registers
    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            pri_q <= `BUCK1_PRI_RST;
            sec_q <= `BUCK1_SEC_RST;
            ctl_q <= `BUCK1_CTL_RST;
        end else if (uvlo_i) begin
            pri_q <= `BUCK1_PRI_RST; // see R16
            sec_q <= `BUCK1_SEC_RST;
            ctl_q <= `BUCK1_CTL_RST;
        end else if (wr_en) begin
            if (wb_adr_i == `OFF_BUCK1_PRI) begin
                pri_q <= wdat & `VSET_WMASK; // see R17
            end
            if (wb_adr_i == `OFF_BUCK1_SEC) begin
                sec_q <= wdat & `VSET_WMASK;
            end
            if (wb_adr_i == `OFF_BUCK1_CTL) begin
                ctl_q <= wdat & `CTL_WMASK; // see R13
            end
        end
    end

    ////////////////////////////////////////////////////////////////
    // Status inputs registered so readback is glitch free
    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            pgood_q <= 1'b0;
            fault_q <= 1'b0;
        end else begin
            pgood_q <= buck1_pgood_i; // see R15
            fault_q <= buck1_fault_i;
        end
    end

    // Events: supply-low in interrupt mode, regulator fault when allowed
    assign irq_set[`IRQ_SYSV_BIT]  = link.low_event & mon_q[`SYS_RESP_BIT]; // see R2
    assign irq_set[`IRQ_FAULT_BIT] = buck1_fault_i & ~fault_q
                                     & ctl_q[`CTL_FLT_BIT]; // see R14

    // Sticky bits; a new event beats a write-one clear
    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            irq_stat_q <= 2'b00;
        end else if (uvlo_i) begin
            irq_stat_q <= 2'b00;
        end else begin
            if (wr_en && wb_adr_i == `OFF_IRQ_STATUS) begin
                irq_stat_q <= (irq_stat_q & ~wdat[1:0]) | irq_set;
            end else begin
                irq_stat_q <= irq_stat_q | irq_set;
            end
        end
    end

    // Mask register; the supply-low path also needs its unmask bit
    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            irq_mask_q <= 2'b00;
        end else if (uvlo_i) begin
            irq_mask_q <= 2'b00;
        end else if (wr_en && wb_adr_i == `OFF_IRQ_MASK) begin
            irq_mask_q <= 2'(wdat & `IRQ_WMASK);
        end
    end

    // Level interrupt, registered
    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= (irq_stat_q[`IRQ_SYSV_BIT] & irq_mask_q[`IRQ_SYSV_BIT]
                      & mon_q[`SYS_UNMASK_BIT]) // see R3
                   | (irq_stat_q[`IRQ_FAULT_BIT] & irq_mask_q[`IRQ_FAULT_BIT]);
        end
    end

    ////////////////////////////////////////////////////////////////
    // Power state: shutdown on master-off or low supply in shutdown mode
    assign shut_req = mst_q[`MST_OFF_BIT]
                    | (sysv_low & ~mon_q[`SYS_RESP_BIT]); // see R2 see R6

    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state_q <= pmu_ctrl_pkg::ST_RUN;
        end else begin
            unique case (state_q)
                pmu_ctrl_pkg::ST_RUN: begin
                    if (shut_req) begin
                        state_q <= pmu_ctrl_pkg::ST_SHDN;
                    end else if (reset_trigger_i) begin
                        state_q <= pmu_ctrl_pkg::ST_HOLD;
                    end
                end
                pmu_ctrl_pkg::ST_HOLD: begin
                    if (shut_req) begin
                        state_q <= pmu_ctrl_pkg::ST_SHDN;
                    end else if (rst_cnt_q == 24'h00_0000) begin
                        state_q <= pmu_ctrl_pkg::ST_RUN;
                    end
                end
                pmu_ctrl_pkg::ST_SHDN: begin
                    if (!shut_req) begin
                        state_q <= pmu_ctrl_pkg::ST_HOLD;
                    end
                end
                default: begin
                    state_q <= pmu_ctrl_pkg::ST_RUN;
                end
            endcase
        end
    end

    // Reset time-out counter; reloads outside the hold state
    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rst_cnt_q <= 24'h00_0000;
        end else if (state_q != pmu_ctrl_pkg::ST_HOLD) begin
            rst_cnt_q <= mon_q[`SYS_TRST_BIT] ? 24'(`RST_SHORT_CYC - 1)
                                              : 24'(`RST_LONG_CYC - 1); // see R1
        end else if (rst_cnt_q != 24'h00_0000) begin
            rst_cnt_q <= rst_cnt_q - 24'h00_0001;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Regulator control outputs, all registered
    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            sysv_threshold_code_o <= 4'h0;
            buck1_voltage_code_o  <= 6'h00;
            buck1_enable_o        <= 1'b0;
            buck1_phase_o         <= 1'b0;
            buck1_force_pwm_o     <= 1'b0;
            buck1_delay_o         <= 3'h0;
            all_regs_off_o        <= 1'b0;
            reset_out_n_o         <= 1'b0;
        end else begin
            sysv_threshold_code_o <= mon_q[3:0]; // see R5
            buck1_voltage_code_o  <= voltage_select_pin_i ? sec_q[5:0] // see R9
                                                          : pri_q[5:0]; // see R8
            buck1_enable_o        <= ctl_q[`CTL_ON_BIT]
                                   & (state_q != pmu_ctrl_pkg::ST_SHDN); // see R10
            buck1_phase_o         <= ctl_q[`CTL_PHASE_BIT]; // see R11
            buck1_force_pwm_o     <= ctl_q[`CTL_MODE_BIT]; // see R12
            buck1_delay_o         <= ctl_q[4:2]; // see R13
            all_regs_off_o        <= state_q == pmu_ctrl_pkg::ST_SHDN; // see R6
            reset_out_n_o         <= state_q == pmu_ctrl_pkg::ST_RUN;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Read data registered with the ack; unmapped reads give zero
    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            wb_dat_o <= 32'h0000_0000;
        end else if (rd_en) begin
            unique case (wb_adr_i)
                `OFF_SYS_MON: begin
                    wb_dat_o <= {24'h00_0000, mon_q[7:5], sysv_low, mon_q[3:0]}; // see R4
                end
                `OFF_SYS_MASTER: begin
                    wb_dat_o <= {24'h00_0000, mst_q}; // see R7
                end
                `OFF_BUCK1_PRI: begin
                    wb_dat_o <= {24'h00_0000, pri_q};
                end
                `OFF_BUCK1_SEC: begin
                    wb_dat_o <= {24'h00_0000, sec_q};
                end
                `OFF_BUCK1_CTL: begin
                    wb_dat_o <= {24'h00_0000, ctl_q[7:1], pgood_q}; // see R15
                end
                `OFF_IRQ_STATUS: begin
                    wb_dat_o <= {24'h00_0000, 6'h00, irq_stat_q};
                end
                `OFF_IRQ_MASK: begin
                    wb_dat_o <= {24'h00_0000, 6'h00, irq_mask_q};
                end
                default: begin
                    wb_dat_o <= 32'h0000_0000;
                end
            endcase
        end
    end
endmodule

// [pmu_ctrl_regs_monitor.sv]
`timescale 1ns/1ps
module pmu_ctrl_regs_monitor (
    input wire logic        core_clk_i,
    input wire logic        reset_n_i,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [7:0]  wb_adr_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic        uvlo_i,
    input wire logic        sysv_below_i,
    input wire logic        push_button_input_n_i,
    input wire logic        voltage_select_pin_i,
    input wire logic        buck1_pgood_i,
    input wire logic        buck1_fault_i,
    input wire logic        reset_trigger_i,
    input wire logic [3:0]  sysv_threshold_code_o,
    input wire logic [5:0]  buck1_voltage_code_o,
    input wire logic        buck1_enable_o,
    input wire logic        buck1_phase_o,
    input wire logic        buck1_force_pwm_o,
    input wire logic [2:0]  buck1_delay_o,
    input wire logic        all_regs_off_o,
    input wire logic        reset_out_n_o,
    input wire logic        irq_o
);
    // Byte write taken at this edge; undervoltage would override it
    wire logic wr_take = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0] && !uvlo_i;

    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!reset_n_i);

    ////////////////////////////////////////////////////////////
    // Bus answer: one cycle late, a single pulse, byte-wide data
    chk_ack_follows: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack not given one cycle after request");
    chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
    chk_rdata_upper: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h00_0000)
        else $error("read data upper bits not zero");
    chk_unmapped_read: assert property (
        wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o && wb_adr_i == 8'h10
        |=> wb_dat_o == 32'h0000_0000)
        else $error("unmapped read not zero");
    // Register to output lag is one edge, so outputs follow two edges after the take
    chk_thresh_write: assert property (
        wr_take && wb_adr_i == 8'h00 ##1 !uvlo_i
        |=> sysv_threshold_code_o == $past(wb_dat_i[3:0], 2))
        else $error("threshold output does not follow write");
    chk_ctl_write: assert property (
        wr_take && wb_adr_i == 8'h22 ##1 !uvlo_i
        |=> {buck1_phase_o, buck1_force_pwm_o, buck1_delay_o} == $past(wb_dat_i[6:2], 2))
        else $error("control outputs do not follow write");
    chk_voltage_select_pin_primary: assert property (
        wr_take && wb_adr_i == 8'h20 && !voltage_select_pin_i
        ##1 !uvlo_i && !voltage_select_pin_i
        |=> buck1_voltage_code_o == $past(wb_dat_i[5:0], 2))
        else $error("primary code not driven with select low");
    chk_voltage_select_pin_secondary: assert property (
        wr_take && wb_adr_i == 8'h21 && voltage_select_pin_i
        ##1 !uvlo_i && voltage_select_pin_i
        |=> buck1_voltage_code_o == $past(wb_dat_i[5:0], 2))
        else $error("secondary code not driven with select high");
    chk_uvlo_defaults: assert property (
        uvlo_i [*2] |=> buck1_voltage_code_o == 6'h24
        && buck1_delay_o == 3'h1 && !buck1_phase_o && buck1_force_pwm_o
        && sysv_threshold_code_o == 4'h0)
        else $error("outputs not at defaults under undervoltage");
    chk_uvlo_irq_off: assert property (uvlo_i [*2] |=> !irq_o)
        else $error("interrupt raised under undervoltage");
endmodule

bind pmu_ctrl_regs pmu_ctrl_regs_monitor u_pmu_ctrl_regs_monitor (
    .core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .uvlo_i(uvlo_i), .sysv_below_i(sysv_below_i),
    .push_button_input_n_i(push_button_input_n_i), .voltage_select_pin_i(voltage_select_pin_i),
    .buck1_pgood_i(buck1_pgood_i), .buck1_fault_i(buck1_fault_i),
    .reset_trigger_i(reset_trigger_i), .sysv_threshold_code_o(sysv_threshold_code_o),
    .buck1_voltage_code_o(buck1_voltage_code_o), .buck1_enable_o(buck1_enable_o),
    .buck1_phase_o(buck1_phase_o), .buck1_force_pwm_o(buck1_force_pwm_o),
    .buck1_delay_o(buck1_delay_o), .all_regs_off_o(all_regs_off_o),
    .reset_out_n_o(reset_out_n_o), .irq_o(irq_o));

// [pmu_ctrl_regs_test.sv]
`timescale 1ns/1ps
module pmu_ctrl_regs_test;
    logic        core_clk_i, reset_n_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, irq_o;
    logic        uvlo_i, sysv_below_i, push_button_input_n_i, voltage_select_pin_i;
    logic        buck1_pgood_i, buck1_fault_i, reset_trigger_i, buck1_enable_o;
    logic        buck1_phase_o, buck1_force_pwm_o, all_regs_off_o, reset_out_n_o;
    logic [7:0]  wb_adr_i;
    logic [3:0]  wb_sel_i, sysv_threshold_code_o;
    logic [31:0] wb_dat_i, wb_dat_o, rd;
    logic [5:0]  buck1_voltage_code_o;
    logic [2:0]  buck1_delay_o;
    int          fails = 0;
    int          num_checks = 0;

    pmu_ctrl_regs u_pmu_ctrl_regs (
        .core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .uvlo_i(uvlo_i), .sysv_below_i(sysv_below_i),
        .push_button_input_n_i(push_button_input_n_i), .voltage_select_pin_i(voltage_select_pin_i),
        .buck1_pgood_i(buck1_pgood_i), .buck1_fault_i(buck1_fault_i),
        .reset_trigger_i(reset_trigger_i), .sysv_threshold_code_o(sysv_threshold_code_o),
        .buck1_voltage_code_o(buck1_voltage_code_o), .buck1_enable_o(buck1_enable_o),
        .buck1_phase_o(buck1_phase_o), .buck1_force_pwm_o(buck1_force_pwm_o),
        .buck1_delay_o(buck1_delay_o), .all_regs_off_o(all_regs_off_o),
        .reset_out_n_o(reset_out_n_o), .irq_o(irq_o));

    // 40 MHz core clock
    initial begin
        core_clk_i = 1'b0;
        forever #12.5 core_clk_i = ~core_clk_i;
    end

    ////////////////////////////////////////////////////////////
    // Shared helpers
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic tally_and_finish();
        $display("Checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic cyc(input int k);
        repeat (k) @(posedge core_clk_i);
    endtask

    // Classic cycle; request stands until ack is sampled, bounded wait
    task automatic wb(input logic we, input logic [7:0] adr, input logic [7:0] dat);
        int n;
        n = 0;
        @(posedge core_clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= adr;
        wb_dat_i <= {24'h00_0000, dat};
        do begin
            @(posedge core_clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        // A missing ack ends the run; nothing may follow the closing report
        if (wb_ack_o !== 1'b1) begin
            fails++;
            tally_and_finish();
        end else begin
            rd = wb_dat_o;
            wb_cyc_i <= 1'b0;
            wb_stb_i <= 1'b0;
            wb_we_i  <= 1'b0;
        end
    endtask

    task automatic rd_chk(input logic [7:0] adr, input logic [7:0] exp, input string what);
        wb(1'b0, adr, 8'h00);
        check(what, rd, {24'h00_0000, exp});
    endtask

    ////////////////////////////////////////////////////////////
    // Scenarios
    task automatic t_defaults();
        rd_chk(8'h00, 8'h00, "mon");
        rd_chk(8'h01, 8'h00, "master");
        rd_chk(8'h20, 8'h24, "pri");
        rd_chk(8'h21, 8'h24, "sec");
        rd_chk(8'h22, 8'hA5, "ctl");
        rd_chk(8'h10, 8'h00, "unmapped");
        check("irq", irq_o, 1'b0);
        check("rst", reset_out_n_o, 1'b1);
        // Hold must outlast a short wait; the full time-out is too long to run
        reset_trigger_i <= 1'b1;
        cyc(1);
        reset_trigger_i <= 1'b0;
        cyc(100);
        check("hold", reset_out_n_o, 1'b0);
        $display("Test defaults done");
    endtask

    // All ones: read-only bits must stay as they are
    task automatic t_rw();
        wb(1'b1, 8'h00, 8'hFF);
        wb(1'b1, 8'h20, 8'hFF);
        wb(1'b1, 8'h21, 8'hFF);
        wb(1'b1, 8'h22, 8'hFF);
        rd_chk(8'h00, 8'hEF, "mon");
        rd_chk(8'h20, 8'h3F, "pri");
        rd_chk(8'h21, 8'h3F, "sec");
        rd_chk(8'h22, 8'hFF, "ctl");
        check("thr", sysv_threshold_code_o, 4'hF);
        check("ctl", {buck1_enable_o, buck1_phase_o, buck1_force_pwm_o,
                      buck1_delay_o}, 6'h3F);
        wb(1'b1, 8'h22, 8'h02);
        buck1_pgood_i <= 1'b0;
        cyc(3);
        check("off", {buck1_enable_o, buck1_phase_o, buck1_force_pwm_o,
                      buck1_delay_o}, 6'h00);
        rd_chk(8'h22, 8'h02, "ctl");
        buck1_pgood_i <= 1'b1;
        wb(1'b1, 8'h22, 8'hA4);
        $display("Test read write done");
    endtask

    task automatic t_voltage_select_pin();
        wb(1'b1, 8'h20, 8'h15);
        cyc(3);
        check("pri", buck1_voltage_code_o, 6'h15);
        // Secondary written while selected, so the new code must reach the pin
        voltage_select_pin_i <= 1'b1;
        wb(1'b1, 8'h21, 8'h2A);
        cyc(3);
        check("sec", buck1_voltage_code_o, 6'h2A);
        voltage_select_pin_i <= 1'b0;
        $display("Test select done");
    endtask

    // Supply low in interrupt mode, unmasked then masked
    task automatic t_sysv();
        wb(1'b1, 8'h81, 8'h03);
        sysv_below_i <= 1'b1;
        cyc(5);
        rd_chk(8'h00, 8'hFF, "mon");
        check("irq", {irq_o, all_regs_off_o}, 2'b10);
        rd_chk(8'h80, 8'h01, "stat");
        sysv_below_i <= 1'b0;
        wb(1'b1, 8'h80, 8'h01);
        cyc(2);
        check("irq", irq_o, 1'b0);
        wb(1'b1, 8'h00, 8'hCF);
        sysv_below_i <= 1'b1;
        cyc(5);
        check("irq", irq_o, 1'b0);
        sysv_below_i <= 1'b0;
        wb(1'b1, 8'h80, 8'h01);
        $display("Test supply monitor done");
    endtask

    task automatic t_fault();
        wb(1'b1, 8'h22, 8'hA6);
        buck1_fault_i <= 1'b1;
        cyc(3);
        check("irq", irq_o, 1'b1);
        buck1_fault_i <= 1'b0;
        wb(1'b1, 8'h80, 8'h02);
        wb(1'b1, 8'h22, 8'hA4);
        buck1_fault_i <= 1'b1;
        cyc(3);
        rd_chk(8'h80, 8'h00, "stat");
        check("irq", irq_o, 1'b0);
        buck1_fault_i <= 1'b0;
        $display("Test fault done");
    endtask

    // Shutdown mode, then master off, push button and undervoltage
    task automatic t_power();
        wb(1'b1, 8'h00, 8'h00);
        sysv_below_i <= 1'b1;
        cyc(5);
        check("shdn", all_regs_off_o, 1'b1);
        sysv_below_i <= 1'b0;
        wb(1'b1, 8'h01, 8'h2F);
        cyc(3);
        check("moff", {all_regs_off_o, buck1_enable_o}, 2'b10);
        push_button_input_n_i <= 1'b0;
        cyc(3);
        rd_chk(8'h01, 8'h0F, "master");
        push_button_input_n_i <= 1'b1;
        uvlo_i <= 1'b1;
        cyc(3);
        uvlo_i <= 1'b0;
        rd_chk(8'h01, 8'h00, "master");
        rd_chk(8'h22, 8'hA5, "ctl");
        $display("Test power done");
    endtask

    ////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        reset_n_i = 1'b0;
        wb_cyc_i = 1'b0;
        wb_stb_i = 1'b0;
        wb_we_i = 1'b0;
        wb_adr_i = 8'h00;
        wb_sel_i = 4'h1;
        wb_dat_i = 32'h0000_0000;
        uvlo_i = 1'b0;
        sysv_below_i = 1'b0;
        push_button_input_n_i = 1'b1;
        voltage_select_pin_i = 1'b0;
        buck1_pgood_i = 1'b1;
        buck1_fault_i = 1'b0;
        reset_trigger_i = 1'b0;
        cyc(5);
        reset_n_i <= 1'b1;
        t_defaults();
        t_rw();
        t_voltage_select_pin();
        t_sysv();
        t_fault();
        t_power();
        tally_and_finish();
    end
endmodule
